// *** common/link_regs_pkg.sv ***
// Shared constants and types for the port selection and pixel frequency registers
package link_regs_pkg;

  localparam logic [7:0] PORT_SEL_OFFSET  = 8'h1e;
  localparam logic [7:0] FREQ_CNT_OFFSET  = 8'h1f;

  localparam int         FIRST_SEL_BIT    = 0;
  localparam int         SECOND_SEL_BIT   = 1;
  localparam int         SEC_ADDR_EN_BIT  = 2;
  localparam int         PORT_SEL_W       = 3;
  localparam logic [2:0] PORT_SEL_RESET   = 3'h1;
  localparam logic [7:0] FREQ_CNT_RESET   = 8'h00;
  localparam logic [7:0] FREQ_CNT_MAX     = 8'hff;

  localparam logic [6:0] SEC_ADDR_STEP    = 7'h01;
  localparam int         RW_BIT           = 0;
  localparam logic [3:0] BYTE_BITS        = 4'h8;

  localparam int         CLK_PERIOD_NS    = 4;
  localparam int         OSC_PERIOD_NS    = 40;
  localparam int         OSC_CYCLES       = (OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [8:0] {
    S_IDLE      = 9'h001,
    S_ADDR      = 9'h002,
    S_ADDR_ACK  = 9'h004,
    S_PTR       = 9'h008,
    S_PTR_ACK   = 9'h010,
    S_WDATA     = 9'h020,
    S_WDATA_ACK = 9'h040,
    S_RDATA     = 9'h080,
    S_RDATA_ACK = 9'h100
  } bus_state_t;

  typedef struct packed {
    logic wr_first;
    logic wr_second;
    logic rd_second;
  } route_t;

  typedef struct packed {
    logic       strobe;
    logic       first;
    logic       second;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_t;

  typedef struct packed {
    logic       second;
    logic [7:0] addr;
  } reg_read_t;

endpackage

// *** sim/i2c_host_model.sv ***
// Serial control host model: drives the bus clock and open-drain data toward the target
`timescale 1ns/10ps
module i2c_host_model (
  input  wire logic clk,
  input  wire logic sda_out,
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda
);
  logic host_low;

  // Pull-up wire: low while either party pulls, high once both have let go
  assign sda = !(host_low || (sda_oe && !sda_out));

  initial begin
    scl      = 1'b1;
    host_low = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Bus clock only moves inside a frame; each phase lasts 4 cycles, above the 3 the target needs
  task automatic frame_start();
    host_low = 1'b0;
    wait_clk(2);
    scl = 1'b1;
    wait_clk(4);
    host_low = 1'b1;
    wait_clk(4);
    scl = 1'b0;
    wait_clk(2);
  endtask

  task automatic frame_stop();
    host_low = 1'b1;
    wait_clk(2);
    scl = 1'b1;
    wait_clk(4);
    host_low = 1'b0;
    wait_clk(4);
  endtask

  // Data moves mid low phase, sampled just before the clock falls
  task automatic bit_io(input logic tx, output logic rx);
    host_low = !tx;
    wait_clk(2);
    scl = 1'b1;
    wait_clk(4);
    rx = sda;
    scl = 1'b0;
    wait_clk(2);
  endtask

  task automatic byte_io(input logic [7:0] tx, input logic ack_tx, output logic [7:0] rx,
                         output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ack_tx, r);
    ack = !r;
  endtask

  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d,
                           output logic ok);
    logic [7:0] rx;
    logic       a0;
    logic       a1;
    logic       a2;
    a1 = 1'b0;
    a2 = 1'b0;
    frame_start();
    byte_io({dev, 1'b0}, 1'b1, rx, a0);
    if (a0) begin
      byte_io(ptr, 1'b1, rx, a1);
      byte_io(d, 1'b1, rx, a2);
    end
    frame_stop();
    ok = a0 && a1 && a2;
  endtask

  // Two-byte reads acknowledge the first byte and refuse the last, as the bus demands
  task automatic read_regs(input logic [6:0] dev, input logic [7:0] ptr, input logic two,
                           output logic [15:0] d, output logic ok);
    logic [7:0] rx;
    logic       a0;
    logic       a1;
    logic       a2;
    logic       dummy;
    a1 = 1'b0;
    a2 = 1'b0;
    d  = 16'h0000;
    frame_start();
    byte_io({dev, 1'b0}, 1'b1, rx, a0);
    if (a0) begin
      byte_io(ptr, 1'b1, rx, a1);
      frame_start();
      byte_io({dev, 1'b1}, 1'b1, rx, a2);
      if (a2) begin
        byte_io(8'hff, !two, d[15:8], dummy);
        if (two) begin
          byte_io(8'hff, 1'b1, d[7:0], dummy);
        end
      end
    end
    frame_stop();
    ok = a0 && a1 && a2;
  endtask
endmodule

// *** sim/port_select_and_freq_counter_test.sv ***
// Self-checking bench for link port steering and pixel frequency measurement
`timescale 1ns/10ps
module port_select_and_freq_counter_test;
  import link_regs_pkg::*;
  `define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin fails++; \
    $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp); end end

  localparam int OSC_NS = 40;
  logic       clk;
  logic       resetn;
  logic       scl;
  logic       sda;
  logic       sda_out;
  logic       sda_oe;
  logic       pixel_clock;
  logic [6:0] pta;
  logic [7:0] ext_rd_data;
  reg_write_t reg_wr;
  reg_write_t wr_seen;
  reg_read_t  reg_rd;
  int         fails = 0;
  int         num_checks = 0;
  int         n_wr = 0;
  int         cycles = 0;
  int         pix_half = 1;

  port_select_regs #(.osc_period_ns(OSC_NS)) port_select_regs_i (
    .clk(clk), .resetn(resetn), .primary_target_address(pta), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .pixel_clock(pixel_clock),
    .ext_rd_data(ext_rd_data), .reg_wr(reg_wr), .reg_rd(reg_rd));

  i2c_host_model i2c_host_model_i (
    .clk(clk), .sda_out(sda_out), .sda_oe(sda_oe), .scl(scl), .sda(sda));

  // Outside registers: second link values differ from first so a wrong route shows
  function automatic logic [7:0] ext_val(input logic second, input logic [7:0] addr);
    return addr ^ (second ? 8'hc3 : 8'h3c);
  endfunction

  // Returns {write first, write second, read second}
  function automatic logic [2:0] route(input logic via_sec, input logic [2:0] sel);
    if (via_sec) return 3'b011;
    if (sel[SEC_ADDR_EN_BIT]) return 3'b100;
    return {sel[FIRST_SEL_BIT], sel[SECOND_SEL_BIT], sel[SECOND_SEL_BIT]};
  endfunction

  task automatic print_verdict();
    $display("Checks %0d, failures %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Pixel clock at most half the system rate so every edge is seen
  initial begin
    pixel_clock = 1'b0;
    forever begin
      repeat (pix_half) @(negedge clk);
      pixel_clock = ~pixel_clock;
    end
  end

  always @(negedge clk) ext_rd_data <= ext_val(reg_rd.second, reg_rd.addr);

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (reg_wr.strobe === 1'b1) begin
      wr_seen <= reg_wr;
      n_wr    <= n_wr + 1;
    end
    if (cycles == 60000) begin
      fails++;
      print_verdict();
    end
  end

  initial begin
    logic        ok;
    logic [15:0] d;
    logic [2:0]  sel;
    logic [2:0]  r;
    logic [7:0]  a;
    logic [7:0]  v;
    int          n0;
    int          n;
    int          c;
    resetn      = 1'b0;
    pta         = 7'h00;
    void'($urandom(32'he2f1));
    pta = 7'($urandom);
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    i2c_host_model_i.read_regs(pta, PORT_SEL_OFFSET, 1'b1, d, ok);
    `CHK(d, {5'h00, PORT_SEL_RESET, FREQ_CNT_RESET})
    // Every steering combination, with garbage in the reserved bits
    for (int s = 0; s < 8; s++) begin
      sel = 3'(s);
      // Select bits rewritten before each pass, then read back with the reserved bits as zero
      i2c_host_model_i.write_reg(pta, PORT_SEL_OFFSET, {5'($urandom), sel}, ok);
      i2c_host_model_i.read_regs(pta, PORT_SEL_OFFSET, 1'b1, d, ok);
      `CHK(d, {5'h00, sel, FREQ_CNT_RESET})
      for (int via = 0; via < 2; via++) begin
        a  = 8'h20 + 8'($urandom % 200);
        v  = 8'($urandom);
        n0 = n_wr;
        // Secondary accesses expected to succeed only once enabled
        i2c_host_model_i.write_reg(pta + 7'(via), a, v, ok);
        `CHK(ok, (via == 0) || sel[SEC_ADDR_EN_BIT])
        if (ok) begin
          r = route(via == 1, sel);
          `CHK(n_wr, n0 + 1)
          `CHK(wr_seen[17:0], {r[2:1], a, v})
          i2c_host_model_i.read_regs(pta + 7'(via), a, 1'b0, d, ok);
          `CHK(d[15:8], ext_val(r[0], a))
          `CHK(d[15:8] == ext_val(1'b1, a), via == 1 || sel[2:1] == 2'b01)
        end
      end
    end
    // Windows: short, full scale, random, then zero which clears the count
    for (int k = 0; k < 4; k++) begin
      n        = (k == 0) ? 20 : (k == 1) ? 255 : (k == 2) ? 1 + $urandom % 40 : 0;
      pix_half = (k == 1) ? 1 : 1 + $urandom % 4;
      i2c_host_model_i.write_reg(pta, FREQ_CNT_OFFSET, 8'(n), ok);
      repeat (n * OSC_NS / CLK_PERIOD_NS + 20) @(negedge clk);
      i2c_host_model_i.read_regs(pta, FREQ_CNT_OFFSET, 1'b0, d, ok);
      c = n * OSC_NS / CLK_PERIOD_NS / (2 * pix_half);
      if (c > 255) `CHK(d[15:8], FREQ_CNT_MAX)
      else `CHK(d[15:8] + 1 >= c && d[15:8] <= c + (n > 0), 1'b1)
    end
    print_verdict();
  end
endmodule

// *** verilog/pixel_freq_counter.sv ***
// Pixel clock edge counter over a window timed in oscillator periods
`timescale 1ns/10ps
module pixel_freq_counter #(
  parameter int osc_cycles = link_regs_pkg::OSC_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       start,
  input  wire logic [7:0] window_value,
  input  wire logic       pixel_clock,
  output logic      [7:0] count,
  output logic            busy
);
  import link_regs_pkg::*;

  localparam int WIN_W = 8 + $clog2(osc_cycles + 1);

  if (osc_cycles < 1) begin : g_bad_cycles
    $error("Window needs at least one clock cycle per oscillator period");
  end

  logic [WIN_W-1:0] win_cnt;
  logic [WIN_W-1:0] next_win_cnt;
  logic [WIN_W-1:0] win_len;
  logic [7:0]       next_count;
  logic             next_busy;
  logic             pix_q;
  logic             pix_rise;

  // Pixel clock is sampled, so it must stay at or below half of clk to be counted faithfully
  assign pix_rise = pixel_clock & ~pix_q;
  assign win_len  = WIN_W'(window_value) * WIN_W'(osc_cycles);

  always_comb begin
    next_win_cnt = win_cnt;
    next_count   = count;
    next_busy    = busy;
    if (start) begin
      next_win_cnt = win_len;
      next_busy    = (win_len != '0);
      next_count   = FREQ_CNT_RESET;
    end else if (busy) begin
      next_win_cnt = WIN_W'(win_cnt - 1'b1);
      next_busy    = (win_cnt != WIN_W'(1));
      if (pix_rise && count != FREQ_CNT_MAX) begin
        next_count = 8'(count + 8'h01);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      win_cnt <= '0;
      count   <= FREQ_CNT_RESET;
      busy    <= 1'b0;
      pix_q   <= 1'b0;
    end else begin
      win_cnt <= next_win_cnt;
      count   <= next_count;
      busy    <= next_busy;
      pix_q   <= pixel_clock;
    end
  end

  // Helper logic for the window length check
  logic [WIN_W-1:0] elapsed;
  logic [WIN_W-1:0] len_seen;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      elapsed  <= '0;
      len_seen <= '0;
    end else if (start) begin
      elapsed  <= '0;
      len_seen <= win_len;
    end else if (busy) begin
      elapsed  <= WIN_W'(elapsed + 1'b1);
    end
  end

  a_start_opens: assert property (@(posedge clk) disable iff (!resetn)
    start && window_value != 8'h00 |=> busy && count == 8'h00)
    else $error("Write did not open a measurement window");

  a_window_len: assert property (@(posedge clk) disable iff (!resetn)
    $fell(busy) && !$past(start) |-> elapsed == len_seen)
    else $error("Window length differs from value times oscillator period");

  a_edge_count: assert property (@(posedge clk) disable iff (!resetn)
    busy && !start && pix_rise && count != 8'hff |=> count == 8'($past(count) + 8'h01))
    else $error("Pixel edge not counted");

  a_count_sat: assert property (@(posedge clk) disable iff (!resetn)
    count == 8'hff && !start |=> count == 8'hff)
    else $error("Frequency count wrapped");

  a_idle_hold: assert property (@(posedge clk) disable iff (!resetn)
    !busy && !start |=> $stable(count))
    else $error("Count changed outside the window");

endmodule

// *** verilog/port_select_regs.sv ***
// Serial control target with link port steering and pixel frequency counter
// Contract
// - Secondary enable set: also answer the primary target address plus one.
// - Secondary address accesses reach second link and common registers.
// - Second select set: primary writes go to second link and common registers.
// - Second select set: primary reads return second link and common registers.
// - First select set: primary writes go to first link and common registers.
// - Both selects set: primary reads return second link values.
// - Secondary enable set: link select bits are ignored for primary accesses.
// - Any write to frequency register starts a pixel edge measurement.
// - Window equals written value times oscillator period, nominally 40 ns.
// - Reading frequency register returns pixel edges counted in the window.
// - Pixel edge count saturates at full scale instead of wrapping.
`timescale 1ns/10ps
module port_select_regs #(
  parameter int osc_period_ns = link_regs_pkg::OSC_PERIOD_NS
) (
  input  wire logic                      clk,
  input  wire logic                      resetn,
  input  wire logic [6:0]                primary_target_address,
  input  wire logic                      scl_in,
  input  wire logic                      sda_in,
  output logic                           sda_out,
  output logic                           sda_oe,
  input  wire logic                      pixel_clock,
  input  wire logic [7:0]                ext_rd_data,
  output link_regs_pkg::reg_write_t      reg_wr,
  output link_regs_pkg::reg_read_t       reg_rd
);
  import link_regs_pkg::*;

  localparam int osc_cycles = (osc_period_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  if (osc_period_ns < CLK_PERIOD_NS) begin : g_bad_period
    $error("Oscillator period shorter than one clock cycle");
  end

  function automatic route_t link_route(input logic via_sec, input logic [2:0] sel);
    route_t r;
    if (via_sec) begin
      r = '{wr_first: 1'b0, wr_second: 1'b1, rd_second: 1'b1};
    end else if (sel[SEC_ADDR_EN_BIT]) begin
      r = '{wr_first: 1'b1, wr_second: 1'b0, rd_second: 1'b0};
    end else begin
      r.wr_first  = sel[FIRST_SEL_BIT];
      r.wr_second = sel[SECOND_SEL_BIT];
      r.rd_second = sel[SECOND_SEL_BIT];
    end
    return r;
  endfunction

  function automatic logic [7:0] read_byte(input logic [7:0] addr, input logic [2:0] sel,
                                           input logic [7:0] freq, input logic [7:0] ext);
    logic [7:0] b;
    b = ext;
    if (addr == PORT_SEL_OFFSET) begin
      b = {5'h00, sel};
    end else if (addr == FREQ_CNT_OFFSET) begin
      b = freq;
    end
    return b;
  endfunction

  bus_state_t  state;
  bus_state_t  next_state;
  logic [3:0]  bit_cnt;
  logic [3:0]  next_bit_cnt;
  logic [7:0]  shreg;
  logic [7:0]  next_shreg;
  logic [7:0]  ptr;
  logic [7:0]  next_ptr;
  logic        rw;
  logic        next_rw;
  logic        via_sec;
  logic        next_via_sec;
  logic        next_sda_oe;
  logic [2:0]  port_sel;
  logic [2:0]  next_port_sel;
  reg_write_t  next_reg_wr;
  reg_read_t   next_reg_rd;
  logic        freq_start;
  logic        next_freq_start;
  logic [7:0]  freq_window;
  logic [7:0]  next_freq_window;
  logic [7:0]  freq_count;
  logic        freq_busy;
  logic        scl_q;
  logic        sda_q;
  logic        start_cond;
  logic        stop_cond;
  logic        scl_rise;
  logic        scl_fall;
  logic        byte_done;
  logic        addr_primary;
  logic        addr_second;
  logic [7:0]  rd_byte;
  route_t      route;

  assign start_cond   = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_cond    = scl_in & scl_q & ~sda_q & sda_in;
  assign scl_rise     = scl_in & ~scl_q;
  assign scl_fall     = ~scl_in & scl_q;
  assign byte_done    = scl_fall && bit_cnt == BYTE_BITS;
  assign addr_primary = shreg[7:1] == primary_target_address;
  assign addr_second  = port_sel[SEC_ADDR_EN_BIT]
                        && shreg[7:1] == 7'(primary_target_address + SEC_ADDR_STEP);
  assign route        = link_route(via_sec, port_sel);
  assign rd_byte      = read_byte(ptr, port_sel, freq_count, ext_rd_data);

  always_comb begin
    next_state       = state;
    next_bit_cnt     = bit_cnt;
    next_shreg       = shreg;
    next_ptr         = ptr;
    next_rw          = rw;
    next_via_sec     = via_sec;
    next_sda_oe      = sda_oe;
    next_port_sel    = port_sel;
    next_freq_start  = 1'b0;
    next_freq_window = freq_window;
    next_reg_wr      = reg_wr;
    next_reg_wr.strobe = 1'b0;
    next_reg_rd      = '{second: route.rd_second, addr: ptr};
    case (state)
      S_IDLE: begin
      end
      S_ADDR, S_PTR, S_WDATA: begin
        if (scl_rise) begin
          next_shreg   = {shreg[6:0], sda_in};
          next_bit_cnt = 4'(bit_cnt + 4'h1);
        end
        if (byte_done) begin
          next_sda_oe = 1'b1;
          if (state == S_ADDR) begin
            if (addr_primary || addr_second) begin
              next_via_sec = addr_second;
              next_rw      = shreg[RW_BIT];
              next_state   = S_ADDR_ACK;
            end else begin
              next_sda_oe  = 1'b0;
              next_state   = S_IDLE;
            end
          end else if (state == S_PTR) begin
            next_ptr   = shreg;
            next_state = S_PTR_ACK;
          end else begin
            next_state = S_WDATA_ACK;
            if (ptr == PORT_SEL_OFFSET) begin
              next_port_sel = shreg[PORT_SEL_W-1:0];
            end else if (ptr == FREQ_CNT_OFFSET) begin
              next_freq_start  = 1'b1;
              next_freq_window = shreg;
            end else begin
              next_reg_wr = '{strobe: 1'b1, first: route.wr_first, second: route.wr_second,
                              addr: ptr, data: shreg};
            end
          end
        end
      end
      S_ADDR_ACK: begin
        if (scl_fall) begin
          next_bit_cnt = 4'h0;
          if (rw) begin
            next_shreg  = rd_byte;
            next_sda_oe = ~rd_byte[7];
            next_state  = S_RDATA;
          end else begin
            next_sda_oe = 1'b0;
            next_state  = S_PTR;
          end
        end
      end
      S_PTR_ACK, S_WDATA_ACK: begin
        if (scl_fall) begin
          next_sda_oe  = 1'b0;
          next_bit_cnt = 4'h0;
          next_state   = S_WDATA;
          if (state == S_WDATA_ACK) begin
            next_ptr = 8'(ptr + 8'h01);
          end
        end
      end
      S_RDATA: begin
        if (scl_rise) begin
          next_bit_cnt = 4'(bit_cnt + 4'h1);
        end
        if (byte_done) begin
          next_sda_oe = 1'b0;
          next_state  = S_RDATA_ACK;
        end else if (scl_fall) begin
          next_shreg  = {shreg[6:0], 1'b0};
          next_sda_oe = ~shreg[6];
        end
      end
      S_RDATA_ACK: begin
        // A not-acknowledge ends the read; the pointer is left on the last byte sent
        if (scl_rise) begin
          if (sda_in) begin
            next_state = S_IDLE;
          end else begin
            next_ptr = 8'(ptr + 8'h01);
          end
        end else if (scl_fall) begin
          next_shreg   = rd_byte;
          next_sda_oe  = ~rd_byte[7];
          next_bit_cnt = 4'h0;
          next_state   = S_RDATA;
        end
      end
      default: begin
        next_state  = S_IDLE;
        next_sda_oe = 1'b0;
      end
    endcase
    if (start_cond) begin
      next_state   = S_ADDR;
      next_bit_cnt = 4'h0;
      next_sda_oe  = 1'b0;
    end else if (stop_cond) begin
      next_state  = S_IDLE;
      next_sda_oe = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state       <= S_IDLE;
      bit_cnt     <= 4'h0;
      shreg       <= 8'h00;
      ptr         <= 8'h00;
      rw          <= 1'b0;
      via_sec     <= 1'b0;
      sda_oe      <= 1'b0;
      sda_out     <= 1'b0;
      port_sel    <= PORT_SEL_RESET;
      freq_start  <= 1'b0;
      freq_window <= 8'h00;
      reg_wr      <= '0;
      reg_rd      <= '0;
      scl_q       <= 1'b1;
      sda_q       <= 1'b1;
    end else begin
      state       <= next_state;
      bit_cnt     <= next_bit_cnt;
      shreg       <= next_shreg;
      ptr         <= next_ptr;
      rw          <= next_rw;
      via_sec     <= next_via_sec;
      sda_oe      <= next_sda_oe;
      sda_out     <= 1'b0;
      port_sel    <= next_port_sel;
      freq_start  <= next_freq_start;
      freq_window <= next_freq_window;
      reg_wr      <= next_reg_wr;
      reg_rd      <= next_reg_rd;
      scl_q       <= scl_in;
      sda_q       <= sda_in;
    end
  end

  pixel_freq_counter #(
    .osc_cycles   (osc_cycles)
  ) u_freq (
    .clk          (clk),
    .resetn       (resetn),
    .start        (freq_start),
    .window_value (freq_window),
    .pixel_clock  (pixel_clock),
    .count        (freq_count),
    .busy         (freq_busy)
  );

  sequence seq_addr_done;
    state == S_ADDR && byte_done && !start_cond && !stop_cond;
  endsequence

  sequence seq_data_done;
    state == S_WDATA && byte_done && !start_cond && !stop_cond;
  endsequence

  a_sec_addr_ack: assert property (@(posedge clk) disable iff (!resetn)
    seq_addr_done ##0 (port_sel[2] && shreg[7:1] == 7'(primary_target_address + SEC_ADDR_STEP))
    |=> state == S_ADDR_ACK && sda_oe && via_sec)
    else $error("Secondary target address not acknowledged");

  a_sec_addr_off: assert property (@(posedge clk) disable iff (!resetn)
    seq_addr_done ##0 (!port_sel[2] && shreg[7:1] != primary_target_address)
    |=> state == S_IDLE && !sda_oe)
    else $error("Address answered while secondary address disabled");

  a_sec_route: assert property (@(posedge clk) disable iff (!resetn)
    reg_wr.strobe && via_sec |-> reg_wr.second && !reg_wr.first)
    else $error("Secondary address write not steered to second link");

  a_second_write: assert property (@(posedge clk) disable iff (!resetn)
    seq_data_done ##0 (!via_sec && port_sel == 3'h2 && ptr > FREQ_CNT_OFFSET)
    |=> reg_wr.strobe && reg_wr.second && !reg_wr.first && reg_wr.data == $past(shreg))
    else $error("Second link select did not steer the write");

  a_second_read: assert property (@(posedge clk) disable iff (!resetn)
    !via_sec && !port_sel[2] && port_sel[1] |=> reg_rd.second && reg_rd.addr == $past(ptr))
    else $error("Second link select did not steer the read");

  a_first_write: assert property (@(posedge clk) disable iff (!resetn)
    reg_wr.strobe && !$past(via_sec) && $past(port_sel) == 3'h1
    |-> reg_wr.first && !reg_wr.second)
    else $error("First link select did not steer the write");

  a_both_read: assert property (@(posedge clk) disable iff (!resetn)
    !via_sec && port_sel == 3'h3 |=> reg_rd.second)
    else $error("Both selects set but read not from second link");

  a_sel_ignored: assert property (@(posedge clk) disable iff (!resetn)
    !via_sec && port_sel[2]
    |=> !reg_rd.second && (!reg_wr.strobe || (reg_wr.first && !reg_wr.second)))
    else $error("Link selects honoured while secondary address enabled");

  a_freq_kick: assert property (@(posedge clk) disable iff (!resetn)
    seq_data_done ##0 (ptr == FREQ_CNT_OFFSET)
    |=> freq_start ##1 (freq_busy || freq_window == 8'h00))
    else $error("Frequency register write did not start a measurement");

  a_reserved_bits: assert property (@(posedge clk) disable iff (!resetn)
    seq_data_done ##0 (ptr == PORT_SEL_OFFSET)
    |=> port_sel == $past(shreg[2:0]) && !reg_wr.strobe)
    else $error("Port select write mishandled");

endmodule
